// ==== slc_pkg.sv ====
// Functional notes
// - auto field detect else forced field select
// - field select: 0=50Hz/625, 1=60Hz/525
// - forced toggle makes odd/even toggle every field
// - time constant 00 TV, 01 VTR, 11 fast
// - PLL open bit fixes horizontal frequency
// - noise modes: normal, fast, free-run, bypass
// - bypass bit disables trap and comb filter
// - comb enable selects comb over chroma trap
// - extra delay: one NTSC, two PAL lines
// - remodulation bandwidth small or large notch
// - sharpness codes 1-3 give strong peaking
// - code 0 plain, 4-7 weak, 8-15 low-pass
package slc_pkg;
  localparam logic [7:0] SYNC_ADDR  = 8'h08;
  localparam logic [7:0] LUMA_ADDR  = 8'h09;
  localparam logic [7:0] SYNC_RESET = 8'h00;
  localparam logic [7:0] LUMA_RESET = 8'h00;
  localparam int AUTO_BIT = 7;
  localparam int RATE_BIT = 6;
  localparam int TGL_BIT  = 5;
  localparam int TC_LSB   = 3;
  localparam int PLL_BIT  = 2;
  localparam int VNR_LSB  = 0;
  localparam int BYP_BIT  = 7;
  localparam int COMB_BIT = 6;
  localparam int DEL_BIT  = 5;
  localparam int BW_BIT   = 4;
  localparam int SHP_LSB  = 0;
  localparam logic [1:0] TC_TV   = 2'h0;
  localparam logic [1:0] TC_VTR  = 2'h1;
  localparam logic [1:0] TC_RSV  = 2'h2;
  localparam logic [1:0] TC_FAST = 2'h3;
  localparam logic [1:0] VNR_NORMAL = 2'h0;
  localparam logic [1:0] VNR_FAST   = 2'h1;
  localparam logic [1:0] VNR_FREE   = 2'h2;
  localparam logic [1:0] VNR_BYPASS = 2'h3;
  // luminance filter path selection
  typedef enum logic [1:0] {
    SLC_Y_TRAP   = 2'h0,
    SLC_Y_COMB   = 2'h1,
    SLC_Y_BYPASS = 2'h3
  } slc_ypath_t;
  // sharpness classes
  typedef enum logic [1:0] {
    SLC_SH_PLAIN  = 2'h0,
    SLC_SH_STRONG = 2'h1,
    SLC_SH_WEAK   = 2'h3,
    SLC_SH_LOWP   = 2'h2
  } slc_shclass_t;
  localparam logic [3:0] SH_STRONG_MAX = 4'h3;
  localparam logic [3:0] SH_WEAK_MAX   = 4'h7;
  localparam logic [1:0] DEL_NONE = 2'h0;
  localparam logic [1:0] DEL_NTSC = 2'h1;
  localparam logic [1:0] DEL_PAL  = 2'h2;
endpackage

// ==== slc_regs.sv ====
`timescale 1ns/1ps
module slc_regs (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // register port
  input  wire logic       i_wr,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // field status from sync processing
  input  wire logic       i_det_60hz,
  input  wire logic       i_field_end,
  input  wire logic       i_interlaced,
  // sync controls
  output logic            o_field_60hz,
  output logic            o_odd_even,
  output logic      [1:0] o_horiz_time_constant,
  output logic            o_horiz_pll_open,
  output logic      [1:0] o_vert_noise_mode,
  // luminance controls
  output logic      [1:0] o_luma_path,
  output logic      [1:0] o_extra_line_delay,
  output logic            o_remod_bandwidth_sel,
  output logic      [1:0] o_sharpness_class,
  output logic      [3:0] o_sharpness_filter_sel
);
  logic [7:0] sync_q;
  logic [7:0] luma_q;
  logic       field_60_d;
  logic [1:0] path_d;
  logic [1:0] del_d;
  logic [1:0] shc_d;
  logic [3:0] shp;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync_q <= slc_pkg::SYNC_RESET;
    end else if (i_wr && i_addr == slc_pkg::SYNC_ADDR) begin
      sync_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      luma_q <= slc_pkg::LUMA_RESET;
    end else if (i_wr && i_addr == slc_pkg::LUMA_ADDR) begin
      luma_q <= i_wdata;
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_addr == slc_pkg::SYNC_ADDR) begin
      o_rdata <= sync_q;
    end else if (i_addr == slc_pkg::LUMA_ADDR) begin
      o_rdata <= luma_q;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  always_comb begin
    field_60_d = sync_q[slc_pkg::AUTO_BIT] ? i_det_60hz
                                           : sync_q[slc_pkg::RATE_BIT];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_field_60hz <= 1'b0;
    end else begin
      o_field_60hz <= field_60_d;
    end
  end

  // a progressive source still toggles when forced, so field parity
  // downstream never stalls on a single-field source
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_odd_even <= 1'b0;
    end else if (i_field_end
                 && (i_interlaced || sync_q[slc_pkg::TGL_BIT])) begin
      o_odd_even <= ~o_odd_even;
    end
  end

  // reserved time constant code passed through; host must avoid it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_horiz_time_constant <= slc_pkg::TC_TV;
      o_horiz_pll_open      <= 1'b0;
      o_vert_noise_mode     <= slc_pkg::VNR_NORMAL;
    end else begin
      o_horiz_time_constant <= sync_q[slc_pkg::TC_LSB +: 2];
      o_horiz_pll_open      <= sync_q[slc_pkg::PLL_BIT];
      o_vert_noise_mode     <= sync_q[slc_pkg::VNR_LSB +: 2];
    end
  end

  always_comb begin
    if (luma_q[slc_pkg::BYP_BIT]) begin
      path_d = slc_pkg::SLC_Y_BYPASS;
    end else if (luma_q[slc_pkg::COMB_BIT]) begin
      path_d = slc_pkg::SLC_Y_COMB;
    end else begin
      path_d = slc_pkg::SLC_Y_TRAP;
    end
  end

  // extra delay only applies outside comb mode
  always_comb begin
    if (!luma_q[slc_pkg::DEL_BIT] || path_d == slc_pkg::SLC_Y_COMB) begin
      del_d = slc_pkg::DEL_NONE;
    end else if (field_60_d) begin
      del_d = slc_pkg::DEL_NTSC;
    end else begin
      del_d = slc_pkg::DEL_PAL;
    end
  end

  assign shp = luma_q[slc_pkg::SHP_LSB +: 4];

  always_comb begin
    if (shp == 4'h0) begin
      shc_d = slc_pkg::SLC_SH_PLAIN;
    end else if (shp <= slc_pkg::SH_STRONG_MAX) begin
      shc_d = slc_pkg::SLC_SH_STRONG;
    end else if (shp <= slc_pkg::SH_WEAK_MAX) begin
      shc_d = slc_pkg::SLC_SH_WEAK;
    end else begin
      shc_d = slc_pkg::SLC_SH_LOWP;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_luma_path            <= slc_pkg::SLC_Y_TRAP;
      o_extra_line_delay     <= slc_pkg::DEL_NONE;
      o_remod_bandwidth_sel  <= 1'b0;
      o_sharpness_class      <= slc_pkg::SLC_SH_PLAIN;
      o_sharpness_filter_sel <= 4'h0;
    end else begin
      o_luma_path            <= path_d;
      o_extra_line_delay     <= del_d;
      o_remod_bandwidth_sel  <= luma_q[slc_pkg::BW_BIT];
      o_sharpness_class      <= shc_d;
      o_sharpness_filter_sel <= shp;
    end
  end

  sequence wr_sync_s;
    i_wr && i_addr == slc_pkg::SYNC_ADDR;
  endsequence

  sequence wr_luma_s;
    i_wr && i_addr == slc_pkg::LUMA_ADDR;
  endsequence

  // a write in the next cycle reaches sync_q on the same edge that o_rdata samples the byte under test
  sequence read_sync_s;
    !i_wr && i_addr == slc_pkg::SYNC_ADDR;
  endsequence

  sequence read_luma_s;
    !i_wr && i_addr == slc_pkg::LUMA_ADDR;
  endsequence

  property readback_p;
    @(posedge i_clk) disable iff (!i_rst_n)
      (wr_sync_s ##1 read_sync_s) |=> o_rdata == $past(i_wdata, 2);
  endproperty

  property luma_readback_p;
    @(posedge i_clk) disable iff (!i_rst_n)
      (wr_luma_s ##1 read_luma_s) |=> o_rdata == $past(i_wdata, 2);
  endproperty

  sync_readback_a: assert property (readback_p)
    else $error("sync register readback mismatch");

  luma_readback_a: assert property (luma_readback_p)
    else $error("luminance register readback mismatch");

  sync_store_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    wr_sync_s |=> sync_q == $past(i_wdata))
    else $error("sync register write lost");

  unmapped_read_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_addr != slc_pkg::SYNC_ADDR && i_addr != slc_pkg::LUMA_ADDR)
      |=> o_rdata == 8'h00)
    else $error("unmapped address read not zero");

  forced_field_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !sync_q[slc_pkg::AUTO_BIT]
      |=> o_field_60hz == $past(sync_q[slc_pkg::RATE_BIT]))
    else $error("forced field rate not followed");

  auto_field_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    sync_q[slc_pkg::AUTO_BIT]
      |=> o_field_60hz == $past(i_det_60hz))
    else $error("detected field rate not followed");

  odd_even_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_field_end && !i_interlaced && !sync_q[slc_pkg::TGL_BIT])
      |=> $stable(o_odd_even))
    else $error("odd/even toggled on progressive source");

  odd_even_forced_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_field_end && sync_q[slc_pkg::TGL_BIT])
      |=> o_odd_even != $past(o_odd_even))
    else $error("forced odd/even toggle missing");

  odd_even_inter_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_field_end && i_interlaced)
      |=> o_odd_even != $past(o_odd_even))
    else $error("interlaced odd/even toggle missing");

  time_const_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (wr_sync_s ##1 !i_wr) |=> o_horiz_time_constant
      == $past(i_wdata[slc_pkg::TC_LSB +: 2], 2))
    else $error("time constant not applied");

  pll_open_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    ##1 o_horiz_pll_open == $past(sync_q[slc_pkg::PLL_BIT]))
    else $error("pll open state wrong");

  noise_mode_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    ##1 o_vert_noise_mode == $past(sync_q[slc_pkg::VNR_LSB +: 2]))
    else $error("noise mode wrong");

  bypass_path_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    luma_q[slc_pkg::BYP_BIT]
      |=> o_luma_path == slc_pkg::SLC_Y_BYPASS)
    else $error("filter bypass not applied");

  comb_path_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (!luma_q[slc_pkg::BYP_BIT] && luma_q[slc_pkg::COMB_BIT])
      |=> o_luma_path == slc_pkg::SLC_Y_COMB)
    else $error("comb path not selected");

  trap_path_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (!luma_q[slc_pkg::BYP_BIT] && !luma_q[slc_pkg::COMB_BIT])
      |=> o_luma_path == slc_pkg::SLC_Y_TRAP)
    else $error("chroma trap path not selected");

  line_delay_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (luma_q[slc_pkg::DEL_BIT] && !luma_q[slc_pkg::BYP_BIT]
     && !luma_q[slc_pkg::COMB_BIT] && !field_60_d)
      |=> o_extra_line_delay == slc_pkg::DEL_PAL)
    else $error("pal line delay wrong");

  ntsc_delay_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (luma_q[slc_pkg::DEL_BIT] && !luma_q[slc_pkg::BYP_BIT]
     && !luma_q[slc_pkg::COMB_BIT] && field_60_d)
      |=> o_extra_line_delay == slc_pkg::DEL_NTSC)
    else $error("ntsc line delay wrong");

  bandwidth_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    ##1 o_remod_bandwidth_sel == $past(luma_q[slc_pkg::BW_BIT]))
    else $error("remodulation bandwidth wrong");

  sharp_plain_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (shp == 4'h0)
      |=> o_sharpness_class == slc_pkg::SLC_SH_PLAIN)
    else $error("plain class wrong");

  sharp_strong_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (shp != 4'h0 && shp <= slc_pkg::SH_STRONG_MAX)
      |=> o_sharpness_class == slc_pkg::SLC_SH_STRONG)
    else $error("strong peaking class wrong");

  sharp_weak_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (shp > slc_pkg::SH_STRONG_MAX && shp <= slc_pkg::SH_WEAK_MAX)
      |=> o_sharpness_class == slc_pkg::SLC_SH_WEAK)
    else $error("weak peaking class wrong");

  sharp_lowpass_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    shp[3]
      |=> o_sharpness_class == slc_pkg::SLC_SH_LOWP)
    else $error("low-pass class wrong");
endmodule

// ==== tb_slc_regs.sv ====
`timescale 1ns/1ps
module tb_slc_regs;
  logic       i_clk        = 1'b0;
  logic       i_rst_n      = 1'b0;
  logic       i_wr         = 1'b0;
  logic [7:0] i_addr       = 8'h00;
  logic [7:0] i_wdata      = 8'h00;
  logic       i_det_60hz   = 1'b0;
  logic       i_field_end  = 1'b0;
  logic       i_interlaced = 1'b0;
  logic [7:0] o_rdata;
  logic       o_field_60hz;
  logic       o_odd_even;
  logic       o_pll;
  logic       o_bw;
  logic [1:0] o_tc;
  logic [1:0] o_vnr;
  logic [1:0] o_path;
  logic [1:0] o_del;
  logic [1:0] o_cls;
  logic [3:0] o_sel;
  int         miscompares = 0;
  int         num_checks  = 0;

  always #10 i_clk = ~i_clk;

  slc_regs u_slc_regs (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_det_60hz(i_det_60hz),
    .i_field_end(i_field_end), .i_interlaced(i_interlaced),
    .o_field_60hz(o_field_60hz), .o_odd_even(o_odd_even),
    .o_horiz_time_constant(o_tc), .o_horiz_pll_open(o_pll),
    .o_vert_noise_mode(o_vnr), .o_luma_path(o_path),
    .o_extra_line_delay(o_del), .o_remod_bandwidth_sel(o_bw),
    .o_sharpness_class(o_cls), .o_sharpness_filter_sel(o_sel)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // controls land one edge after the register, so two edges always suffice
  task automatic settle;
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    settle();
  endtask

  task automatic field(input logic il);
    @(posedge i_clk);
    i_interlaced <= il;
    i_field_end  <= 1'b1;
    @(posedge i_clk);
    i_field_end <= 1'b0;
    settle();
  endtask

  task automatic t_sync;
    logic [7:0] d;
    for (int h = 0; h < 4; h++) begin
      for (int v = 0; v < 4; v++) begin
        d = {3'h0, 2'(h), 1'(h ^ v), 2'(v)};
        // auto detect stays off, so fast noise mode 01 is legal
        wr(slc_pkg::SYNC_ADDR, d);
        chk(o_rdata, d);
        chk({6'h0, o_tc}, {6'h0, 2'(h)});
        chk({7'h0, o_pll}, {7'h0, 1'(h ^ v)});
        chk({6'h0, o_vnr}, {6'h0, 2'(v)});
      end
    end
    // unmapped place reads zero and a write there leaves the luminance register alone
    wr(8'h0a, 8'hff);
    chk(o_rdata, 8'h00);
    wr(slc_pkg::LUMA_ADDR, 8'h5a);
    wr(8'h07, 8'h00);
    @(posedge i_clk);
    i_addr <= slc_pkg::LUMA_ADDR;
    settle();
    chk(o_rdata, 8'h5a);
  endtask

  task automatic t_rate;
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clk);
      i_det_60hz <= k[0];
      wr(slc_pkg::SYNC_ADDR, {k[2], k[1], 6'h18});
      chk({7'h0, o_field_60hz}, {7'h0, k[2] ? k[0] : k[1]});
    end
  endtask

  task automatic t_toggle;
    wr(slc_pkg::SYNC_ADDR, 8'h18);
    field(1'b0);
    chk({7'h0, o_odd_even}, 8'h00);
    field(1'b1);
    chk({7'h0, o_odd_even}, 8'h01);
    wr(slc_pkg::SYNC_ADDR, 8'h38);
    field(1'b0);
    chk({7'h0, o_odd_even}, 8'h00);
  endtask

  task automatic t_luma;
    logic [1:0] ce;
    for (int k = 0; k < 4; k++) begin
      wr(slc_pkg::LUMA_ADDR, {k[1], k[0], 6'h00});
      ce = k[1] ? 2'h3 : {1'b0, k[0]};
      chk({6'h0, o_path}, {6'h0, ce});
    end
    wr(slc_pkg::SYNC_ADDR, 8'h40);
    wr(slc_pkg::LUMA_ADDR, 8'h20);
    chk({6'h0, o_del}, {6'h0, slc_pkg::DEL_NTSC});
    wr(slc_pkg::SYNC_ADDR, 8'h00);
    chk({6'h0, o_del}, {6'h0, slc_pkg::DEL_PAL});
    wr(slc_pkg::LUMA_ADDR, 8'h60);
    chk({6'h0, o_del}, {6'h0, slc_pkg::DEL_NONE});
    wr(slc_pkg::LUMA_ADDR, 8'h10);
    chk({7'h0, o_bw}, 8'h01);
    for (int s = 0; s < 16; s++) begin
      wr(slc_pkg::LUMA_ADDR, {4'h0, 4'(s)});
      if (s == 0) ce = slc_pkg::SLC_SH_PLAIN;
      else if (s < 4) ce = slc_pkg::SLC_SH_STRONG;
      else if (s < 8) ce = slc_pkg::SLC_SH_WEAK;
      else ce = slc_pkg::SLC_SH_LOWP;
      chk({4'h0, o_sel}, {4'h0, 4'(s)});
      chk({6'h0, o_cls}, {6'h0, ce});
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    summarize();
  end

  initial begin
    i_addr <= slc_pkg::SYNC_ADDR;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    settle();
    chk(o_rdata, 8'h00);
    chk({o_field_60hz, o_odd_even, o_pll, o_bw, o_tc, o_vnr}, 8'h00);
    t_sync();
    t_rate();
    t_toggle();
    t_luma();
    summarize();
  end
endmodule
